// ---- verilog/disk_status_map.vh ----
`ifndef DISK_STATUS_MAP_VH
`define DISK_STATUS_MAP_VH

// Register byte offsets
`define OFF_XFER_STATUS 12'h000
`define OFF_UNIT_STATUS 12'h004
`define OFF_UNIT_ADDR_CTRL 12'h008
`define OFF_SECOND_CTRL 12'h00C

// Transfer status channel fields
`define XS_UNIT_SEL 8
`define XS_FULL 9
`define XS_READ_ERR 10
`define XS_TAG_CHK_ERR 11
`define XS_END_PAGE 12
`define XS_BANK_LO 13

// Unit status channel fields
`define US_ON_SECTOR 8
`define US_BUSY 9
`define US_READY 10
`define US_SEEK_ERR 11
`define US_ON_CYL 12
`define US_UNSAFE 13
`define US_XFER_ERR 14
`define US_NOT_DONE 15

// Control channel, unit meaning
`define UC_RELEASE 0
`define UC_SECTOR_SEL 1
`define UC_DIFF_SEL 2
`define UC_CLEAR 3
`define UC_LOGIC_LO 4
`define UC_UNIT_SEL 7
`define UC_AC_LO 8

// Control channel, address meaning
`define AC_WRITE_TAGS 0
`define AC_FULL 1
`define AC_PROCEED 2
`define AC_ODD 3
`define AC_PAGE_LO 4
`define AC_WRITE 8
`define AC_HEADER_LO 10

// Second control channel fields
`define SC_LOAD_ADDR 0
`define SC_BEGIN 1

// Reset values
`define RST_HALF 16'h0000
`define RST_SECOND 2'h0

// Words per data page and check word polynomial
`define PAGE_WORDS_DEF 512
`define CHECK_POLY 16'h8005

`endif

// ---- verilog/sync2.v ----
module sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

reg [W-1:0] meta_reg;

// First stage feeds only the second stage
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    meta_reg <= {W{1'b0}};
    q <= {W{1'b0}};
  end else begin
    meta_reg <= d;
    q <= meta_reg;
  end
end

endmodule // sync2

// ---- verilog/check_word16.v ----
module check_word16 #(
  parameter [15:0] POLY = 16'h8005
) (
  // Running check word and next data word
  input wire [15:0] crc_in,
  input wire [15:0] data,
  output reg [15:0] crc_out
);

integer i;
reg fb;

// Bit-serial update unrolled by the loop, MSB first
always @* begin
  crc_out = crc_in;
  fb = 1'b0;
  for (i = 15; i >= 0; i = i - 1) begin
    fb = crc_out[15] ^ data[i];
    crc_out = {crc_out[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
  end
end

endmodule // check_word16

// ---- verilog/disk_interface_status_control.v ----
`include "disk_status_map.vh"

module disk_interface_status_control #(
  parameter PAGE_WORDS = `PAGE_WORDS_DEF,
  parameter [15:0] CHECK_POLY = `CHECK_POLY
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Drive status lines
  input wire [8:0] unit_selected_in,
  input wire [8:0] on_sector_in,
  input wire busy_in,
  input wire ready_in,
  input wire seek_error_in,
  input wire on_cylinder_in,
  input wire pack_unsafe_in,
  // Drive control lines
  output reg drv_strobe,
  output reg drv_release,
  output reg drv_clear,
  output reg drv_sector_select,
  output reg drv_diff_select,
  output reg [2:0] drv_unit_code,
  output reg drv_unit_select,
  output reg [7:0] drv_addr_ctrl,
  // Buffer memory
  output reg mem_addr_strobe,
  output reg [3:0] mem_page,
  output reg [5:0] mem_header,
  output reg mem_odd,
  input wire [15:0] mem_tag,
  input wire mem_parity_err,
  input wire [2:0] mem_bank,
  // Disk word stream
  input wire word_valid,
  input wire [15:0] word_data,
  // Timing control
  output reg xfer_active,
  output reg xfer_write,
  output reg write_tags_en
);

////////////////////////////////////////////////////////////////////////
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_TAG = 5'h02;
localparam [4:0] ST_TAGCHK = 5'h04;
localparam [4:0] ST_DATA = 5'h08;
localparam [4:0] ST_DATACHK = 5'h10;
localparam CW = $clog2(PAGE_WORDS + 1);
localparam [CW-1:0] LAST_WORD = PAGE_WORDS - 1;

////////////////////////////////////////////////////////////////////////
// Drive lines come from another domain
wire [22:0] drv_sync;

sync2 #(
  .W(23)
) u_sync (
  .clk(pclk),
  .rst_n(presetn),
  .d({unit_selected_in, on_sector_in, busy_in, ready_in,
      seek_error_in, on_cylinder_in, pack_unsafe_in}),
  .q(drv_sync)
);

wire [8:0] unit_sel_s = drv_sync[22:14];
wire [8:0] on_sector_s = drv_sync[13:5];
wire busy_s = drv_sync[4];
wire ready_s = drv_sync[3];
wire seek_err_s = drv_sync[2];
wire on_cyl_s = drv_sync[1];
wire unsafe_s = drv_sync[0];

////////////////////////////////////////////////////////////////////////
// Register state
reg [1:0] second_reg;
reg full_reg;
reg proceed_reg;
reg write_reg;
reg write_tags_reg;
reg read_err_reg;
reg tag_chk_err_reg;
reg tag_cmp_err_reg;
reg end_page_reg;
reg not_done_reg;
reg [2:0] bank_code_reg;
reg [4:0] state_reg;
reg [CW-1:0] count_reg;
reg [15:0] crc_reg;
reg [15:0] tag_crc_reg;

wire setup = psel && !penable;
wire wr_access = psel && penable && pwrite;
wire load_addr_mode = second_reg[`SC_LOAD_ADDR];
wire ctrl_wr = wr_access && (paddr == `OFF_UNIT_ADDR_CTRL);
wire unit_wr = ctrl_wr && !load_addr_mode;
wire addr_wr = ctrl_wr && load_addr_mode;

// Unit index: unit select bit picks the standby position
wire [3:0] unit_idx = drv_unit_select ? 4'h8 : {1'b0, drv_unit_code};
wire unit_selected_bit = unit_sel_s[unit_idx];
wire on_sector_bit = on_sector_s[unit_idx];

////////////////////////////////////////////////////////////////////////
// Status words
wire xfer_err = read_err_reg || tag_chk_err_reg || tag_cmp_err_reg;
wire [15:0] xfer_status;
wire [15:0] unit_status;

assign xfer_status = {bank_code_reg, end_page_reg, tag_chk_err_reg,
                      read_err_reg, full_reg, unit_selected_bit,
                      8'h00};
// not-finished bit is active high while the page runs
assign unit_status = {not_done_reg, xfer_err, unsafe_s, on_cyl_s,
                      seek_err_s, ready_s, busy_s, on_sector_bit,
                      8'h00};

////////////////////////////////////////////////////////////////////////
// APB answers in the access cycle right after setup
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end else begin
    pready <= setup;
    pslverr <= 1'b0;
    prdata <= 32'h00000000;
    if (setup) begin
      case (paddr)
        `OFF_XFER_STATUS: prdata <= {16'h0000, xfer_status};
        `OFF_UNIT_STATUS: prdata <= {16'h0000, unit_status};
        `OFF_UNIT_ADDR_CTRL: prdata <= 32'h00000000;
        `OFF_SECOND_CTRL: prdata <= {30'h00000000, second_reg};
        default: pslverr <= 1'b1;
      endcase
    end
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    second_reg <= `RST_SECOND;
  end else if (wr_access && paddr == `OFF_SECOND_CTRL) begin
    second_reg <= pwdata[1:0];
  end
end

////////////////////////////////////////////////////////////////////////
// Drive control outputs, unit meaning of the control channel
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    drv_strobe <= 1'b0;
    drv_release <= 1'b0;
    drv_clear <= 1'b0;
    drv_sector_select <= 1'b0;
    drv_diff_select <= 1'b0;
    drv_unit_code <= 3'h0;
    drv_unit_select <= 1'b0;
    drv_addr_ctrl <= 8'h00;
  end else begin
    drv_strobe <= unit_wr;
    drv_release <= unit_wr && pwdata[`UC_RELEASE];
    drv_clear <= unit_wr && pwdata[`UC_CLEAR];
    if (unit_wr) begin
      drv_sector_select <= pwdata[`UC_SECTOR_SEL];
      drv_diff_select <= pwdata[`UC_DIFF_SEL];
      drv_unit_code <= {pwdata[`UC_LOGIC_LO], pwdata[`UC_LOGIC_LO+1],
                        pwdata[`UC_LOGIC_LO+2]};
      drv_unit_select <= pwdata[`UC_UNIT_SEL];
      // Field bits 8..15 carry address/control 7 down to 0
      drv_addr_ctrl <= {pwdata[`UC_AC_LO], pwdata[`UC_AC_LO+1],
                        pwdata[`UC_AC_LO+2], pwdata[`UC_AC_LO+3],
                        pwdata[`UC_AC_LO+4], pwdata[`UC_AC_LO+5],
                        pwdata[`UC_AC_LO+6], pwdata[`UC_AC_LO+7]};
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Check word units: tag field and data page
wire [15:0] crc_next;
wire [15:0] tag_crc_next;

check_word16 #(
  .POLY(CHECK_POLY)
) u_data_crc (
  .crc_in(crc_reg),
  .data(word_data),
  .crc_out(crc_next)
);

check_word16 #(
  .POLY(CHECK_POLY)
) u_tag_crc (
  .crc_in(16'h0000),
  .data(word_data),
  .crc_out(tag_crc_next)
);

////////////////////////////////////////////////////////////////////////
// Transfer sequencer
wire start = state_reg[0] && full_reg && proceed_reg &&
             second_reg[`SC_BEGIN];
wire read_fail = (state_reg[3] && mem_parity_err) ||
                 (state_reg[4] && word_valid && word_data != crc_reg);
wire page_end = (state_reg[3] && word_valid && write_reg &&
                 count_reg == LAST_WORD) ||
                (state_reg[4] && word_valid);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_reg <= ST_IDLE;
    count_reg <= {CW{1'b0}};
    crc_reg <= 16'h0000;
    tag_crc_reg <= 16'h0000;
  end else begin
    case (state_reg)
      ST_IDLE: begin
        count_reg <= {CW{1'b0}};
        crc_reg <= 16'h0000;
        if (start) begin
          // Writes skip the tag check: the tags are ours
          state_reg <= write_reg ? ST_DATA : ST_TAG;
        end
      end
      ST_TAG: begin
        if (word_valid) begin
          tag_crc_reg <= tag_crc_next;
          state_reg <= ST_TAGCHK;
        end
      end
      ST_TAGCHK: begin
        if (word_valid) begin
          state_reg <= ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_valid) begin
          crc_reg <= crc_next;
          count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
          if (count_reg == LAST_WORD) begin
            state_reg <= write_reg ? ST_IDLE : ST_DATACHK;
          end
        end
      end
      ST_DATACHK: begin
        if (word_valid) begin
          state_reg <= ST_IDLE;
        end
      end
      default: state_reg <= ST_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Address register, full and proceed
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    full_reg <= 1'b0;
    proceed_reg <= 1'b0;
    write_reg <= 1'b0;
    write_tags_reg <= 1'b0;
    mem_page <= 4'h0;
    mem_header <= 6'h00;
    mem_odd <= 1'b0;
    mem_addr_strobe <= 1'b0;
  end else begin
    mem_addr_strobe <= start;
    if (start) begin
      full_reg <= 1'b0;
      proceed_reg <= 1'b0;
    end
    // A new address overrides the clear; software waits on full
    if (addr_wr) begin
      full_reg <= pwdata[`AC_FULL];
      proceed_reg <= pwdata[`AC_PROCEED];
      write_reg <= pwdata[`AC_WRITE];
      write_tags_reg <= pwdata[`AC_WRITE_TAGS];
      mem_odd <= pwdata[`AC_ODD];
      mem_page <= {pwdata[`AC_PAGE_LO], pwdata[`AC_PAGE_LO+1],
                   pwdata[`AC_PAGE_LO+2], pwdata[`AC_PAGE_LO+3]};
      mem_header <= pwdata[`AC_HEADER_LO+5:`AC_HEADER_LO];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Error and completion flags; a start clears them and sets not-done, events win
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    read_err_reg <= 1'b0;
    tag_chk_err_reg <= 1'b0;
    tag_cmp_err_reg <= 1'b0;
    end_page_reg <= 1'b0;
    not_done_reg <= 1'b0;
    bank_code_reg <= 3'h0;
  end else begin
    if (start) begin
      read_err_reg <= 1'b0;
      tag_chk_err_reg <= 1'b0;
      tag_cmp_err_reg <= 1'b0;
      end_page_reg <= 1'b0;
      not_done_reg <= 1'b1;
    end
    if (state_reg[1] && word_valid && word_data != mem_tag) begin
      tag_cmp_err_reg <= 1'b1;
    end
    if (state_reg[2] && word_valid && word_data != tag_crc_reg) begin
      tag_chk_err_reg <= 1'b1;
    end
    if (read_fail) begin
      read_err_reg <= 1'b1;
      if (!read_err_reg) begin
        bank_code_reg <= ~mem_bank;
      end
    end
    if (page_end) begin
      end_page_reg <= 1'b1;
      not_done_reg <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Timing outputs
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    xfer_active <= 1'b0;
    xfer_write <= 1'b0;
    write_tags_en <= 1'b0;
  end else begin
    xfer_active <= !state_reg[0] || start;
    xfer_write <= write_reg;
    write_tags_en <= write_tags_reg && write_reg;
  end
end

endmodule // disk_interface_status_control

// ---- verif/disk_interface_status_control_chk.sv ----
module disk_status_chk (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Drive and transfer
  input wire drv_strobe,
  input wire drv_release,
  input wire mem_addr_strobe,
  input wire xfer_active,
  input wire xfer_write,
  input wire write_tags_en
);
  timeunit 1ns;
  timeprecision 1ns;
  wire acc = psel && penable && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_apb_access: assert property (pready |-> psel && penable)
    else $error("answer outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // The mode register reads back its own low bits
  chk_read_pad: assert property (pready && !pwrite && paddr != 12'h00C |->
    prdata[31:16] == 16'h0 && prdata[7:0] == 8'h0)
    else $error("unused read bits set");
  chk_release_unit: assert property (drv_release |-> drv_strobe)
    else $error("release without strobe");
  chk_strobe_cause: assert property (
    drv_strobe |-> $past(acc) || $past(acc, 2))
    else $error("strobe without write");
  chk_start_pulse: assert property (
    mem_addr_strobe |=> !mem_addr_strobe)
    else $error("start strobe too long");
  chk_start_active: assert property (
    mem_addr_strobe |-> xfer_active)
    else $error("start while idle");
  chk_active_start: assert property (
    $rose(xfer_active) |-> mem_addr_strobe)
    else $error("active without start");
  chk_tags_write: assert property (write_tags_en |-> xfer_write)
    else $error("tags without write");
  cover property (mem_addr_strobe && xfer_write);
  cover property (drv_release);
  cover property (pslverr);
endmodule // disk_status_chk

bind disk_interface_status_control disk_status_chk chk_i (.*);

// ---- verif/disk_partner.sv ----
module disk_partner #(
  parameter PAGE = 4,
  parameter [15:0] TAG = 16'hA5C3,
  parameter [2:0] BANK = 3'h5
) (
  // Clock and bench controls
  input wire pclk,
  input wire presetn,
  input wire [4:0] stat,
  input wire [2:0] fault,
  // From the interface
  input wire mem_addr_strobe,
  input wire xfer_write,
  input wire drv_unit_select,
  input wire [2:0] drv_unit_code,
  // To the interface
  output wire [8:0] unit_selected_in,
  output wire [8:0] on_sector_in,
  output wire busy_in,
  output wire ready_in,
  output wire seek_error_in,
  output wire on_cylinder_in,
  output wire pack_unsafe_in,
  output wire [15:0] mem_tag,
  output wire [2:0] mem_bank,
  output reg mem_parity_err,
  output reg word_valid,
  output reg [15:0] word_data
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [5:0] rev;
  reg [4:0] dly;
  reg [3:0] n;
  reg run;
  reg [15:0] crc;
  wire [3:0] idx = drv_unit_select ? 4'h8 : {1'b0, drv_unit_code};
  wire dat = xfer_write || (n > 4'h1 && n < PAGE + 2);
  wire [3:0] last = xfer_write ? PAGE - 1 : PAGE + 2;
  function automatic logic [15:0] step(input logic [15:0] c, d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ (c[15] ^ d[i] ? 16'h8005 : 16'h0);
    return c;
  endfunction
  wire [15:0] wd = dat ? 16'h3C00 + n : n == 4'h0 ? TAG :
    n == 4'h1 ? step(16'h0, TAG) ^ {15'h0, fault[1]} : crc;
  assign {busy_in, ready_in, seek_error_in, on_cylinder_in,
    pack_unsafe_in} = stat;
  // A ready unit also reports itself selected
  assign unit_selected_in = stat[3] ? 9'h1 << idx : 9'h0;
  // Short revolution keeps the run brief
  assign on_sector_in = on_cylinder_in && rev < 6'h4 ?
    9'h1 << idx : 9'h0;
  assign mem_tag = fault[0] ? ~TAG : TAG;
  assign mem_bank = BANK;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rev, dly, n, run, crc} <= 32'h0;
      {mem_parity_err, word_valid} <= 2'h0;
      word_data <= 16'h0;
    end else begin
      rev <= rev + 6'h1;
      {mem_parity_err, word_valid} <= 2'h0;
      // No stale word between strobes
      word_data <= ~word_data;
      if (mem_addr_strobe) begin
        {dly, n, run, crc} <= {5'hA, 4'h0, 1'b1, 16'h0};
      end else if (dly != 5'h0) begin
        dly <= dly - 5'h1;
      end else if (run && !word_valid) begin
        word_valid <= 1'b1;
        word_data <= wd;
        mem_parity_err <= fault[2] && n == 4'h3;
        if (dat) crc <= step(crc, wd);
        n <= n + 4'h1;
        run <= n != last;
      end
    end
  end
endmodule // disk_partner

// ---- verif/disk_interface_status_control_bench.sv ----
module disk_interface_status_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  reg [4:0] stat = 5'h0;
  reg [2:0] fault = 3'h0;
  wire [31:0] prdata;
  wire [15:0] mem_tag, word_data;
  wire [8:0] unit_selected_in, on_sector_in;
  wire [7:0] drv_addr_ctrl;
  wire [5:0] mem_header;
  wire [3:0] mem_page;
  wire [2:0] drv_unit_code, mem_bank;
  wire pready, pslverr, busy_in, ready_in, seek_error_in;
  wire on_cylinder_in, pack_unsafe_in, drv_strobe, drv_release;
  wire drv_clear, drv_sector_select, drv_diff_select, drv_unit_select;
  wire mem_addr_strobe, mem_odd, mem_parity_err, word_valid;
  wire xfer_active, xfer_write, write_tags_en;
  wire [13:0] ulev = {drv_sector_select, drv_diff_select,
    drv_unit_select, drv_unit_code, drv_addr_ctrl};
  int failures = 0, cmp_count = 0, rel_seen = 0, stb_seen = 0;
  int clr_seen = 0;
  logic [31:0] rd;
  logic err;
  disk_interface_status_control #(.PAGE_WORDS(4)) dut (.*);
  disk_partner #(.PAGE(4)) far (.*);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    rel_seen += drv_release;
    stb_seen += mem_addr_strobe;
    clr_seen += drv_clear;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string s, logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(int i);
    if (i >= 99) begin
      failures++;
      $display("Error wait expected answer seen none");
      final_report;
    end
  endtask
  // Zero wait states expected, but no count is assumed
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 99);
    tmo(i);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] m, e, string s);
    apb(1'b0, a, 32'h0);
    check(s, rd & m, e);
  endtask
  task automatic t_reset;
    rdchk(12'h000, 32'hFFFFFFFF, 32'h0, "xfer status");
    rdchk(12'h004, 32'hFFFFFFFF, 32'h0, "unit status");
    apb(1'b1, 12'h000, 32'hFFFF);
    rdchk(12'h000, 32'hFFFFFFFF, 32'h0, "ro write");
    rdchk(12'h008, 32'hFFFFFFFF, 32'h0, "wo read");
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
  endtask
  task automatic t_unit;
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b1, 12'h008, 32'hE053);
    repeat (2) @(posedge pclk);
    check("release", rel_seen, 32'h1);
    check("sector", ulev, 14'h2507);
    apb(1'b1, 12'h008, 32'h808C);
    repeat (2) @(posedge pclk);
    check("diff", ulev, 14'h1801);
    check("clear", clr_seen, 32'h1);
    check("no release", rel_seen, 32'h1);
  endtask
  task automatic t_status;
    int i;
    stat <= 5'h1F;
    repeat (4) @(posedge pclk);
    rdchk(12'h004, 32'h3E00, 32'h3E00, "drive on");
    rdchk(12'h000, 32'h100, 32'h100, "unit sel on");
    // Poll across one revolution for the on-sector pulse
    rd = 32'h0;
    for (i = 0; i < 40 && rd[8] !== 1'b1; i++) apb(1'b0, 12'h004, 32'h0);
    check("on sector", rd[8], 1'b1);
    stat <= 5'h0;
    repeat (4) @(posedge pclk);
    rdchk(12'h004, 32'h3F00, 32'h0, "drive off");
    rdchk(12'h000, 32'h100, 32'h0, "unit sel off");
  endtask
  task automatic xfer(logic [31:0] c, logic [2:0] f, logic [31:0] m,
    logic [31:0] xs, us);
    int i, s;
    fault <= f;
    apb(1'b1, 12'h00C, 32'h1);
    rdchk(12'h00C, 32'hFFFFFFFF, 32'h1, "mode reg");
    apb(1'b1, 12'h008, c);
    rdchk(12'h000, 32'h200, 32'h200, "full set");
    s = stb_seen;
    apb(1'b1, 12'h00C, 32'h3);
    for (i = 0; i < 99 && stb_seen == s; i++) @(posedge pclk);
    tmo(i);
    check("page", {mem_odd, mem_page, mem_header}, {c[3], 10'h225});
    check("mode", {xfer_write, write_tags_en}, {c[8], c[8] & c[0]});
    rdchk(12'h004, 32'h8000, 32'h8000, "busy xfer");
    rdchk(12'h000, 32'h200, 32'h0, "full drop");
    for (i = 0; i < 99 && xfer_active !== 1'b0; i++) @(posedge pclk);
    tmo(i);
    rdchk(12'h000, m, xs, "xfer end");
    rdchk(12'h004, 32'hC000, us, "unit end");
    apb(1'b1, 12'h00C, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_unit;
    t_status;
    xfer(32'h9416, 3'h0, 32'h1F00, 32'h1000, 32'h0);
    xfer(32'h9416, 3'h1, 32'h1F00, 32'h1000, 32'h4000);
    xfer(32'h9416, 3'h2, 32'h1F00, 32'h1800, 32'h4000);
    xfer(32'h9416, 3'h4, 32'hFC00, 32'h5400, 32'h4000);
    xfer(32'h951F, 3'h0, 32'h1F00, 32'h1000, 32'h0);
    final_report;
  end
endmodule // disk_interface_status_control_bench
